// *** tb/otc_osc_ctrl_test.sv ***
// Self-checking bench for the oscillator trim, start-up and calibration block
`timescale 1ns/100ps
`include "otc_params.svh"
module otc_osc_ctrl_test;
  import otc_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, xtal_enable, crystal_ready_interrupt, slow_rc_fast_sel;
  logic power_up_req = 0, wake_up_req = 0, sleep_req = 0, lp_clk = 0, current_drop = 0;
  logic fast_rc_clk = 0, slow_rc_clk = 0, slow_crystal_clk = 0, enhanced_rc_clk = 0;
  logic ref_clk_16m = 0;
  logic [4:0] bank_a_bin_sel, bank_b_bin_sel;
  logic [6:0] bank_a_therm_sel, bank_b_therm_sel;
  logic [7:0] gp_data, tv;
  logic [31:0] rd, m;
  logic err;
  int errors = 0, check_count = 0, seed = 49352, cyc = 0, irq_count = 0;
  logic [7:0] radr [0:5] = '{`OTC_ADDR_TRIM, `OTC_ADDR_TCTRL, `OTC_ADDR_RDYLIM,
    `OTC_ADDR_CNTLIM, `OTC_ADDR_REFN, `OTC_ADDR_GPD};
  logic [31:0] rval [0:5] = '{32'(`OTC_RST_TRIM), 32'(`OTC_RST_THR) << `OTC_TCTRL_THR_LSB,
    32'(`OTC_RST_RDYLIM), 32'(`OTC_RST_CNTLIM), 32'(`OTC_RST_REFN), 32'(`OTC_RST_GPD)};

  otc_osc_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_up_req(power_up_req), .wake_up_req(wake_up_req),
    .sleep_req(sleep_req), .fast_rc_clk(fast_rc_clk), .lp_clk(lp_clk),
    .current_drop(current_drop), .slow_rc_clk(slow_rc_clk),
    .slow_crystal_clk(slow_crystal_clk), .enhanced_rc_clk(enhanced_rc_clk),
    .ref_clk_16m(ref_clk_16m), .xtal_enable(xtal_enable),
    .crystal_ready_interrupt(crystal_ready_interrupt), .slow_rc_fast_sel(slow_rc_fast_sel),
    .bank_a_bin_sel(bank_a_bin_sel), .bank_a_therm_sel(bank_a_therm_sel),
    .bank_b_bin_sel(bank_b_bin_sel), .bank_b_therm_sel(bank_b_therm_sel), .gp_data(gp_data)
  );

  // ===========================================
  // Clocks
  always #20 pclk = ~pclk;

  // Measured sources have half periods of 3, 4, 5 and 6 cycles so a wrong
  // source selection gives a clearly different count
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ref_clk_16m <= ~ref_clk_16m;
    slow_rc_clk <= (cyc % 6) < 3;
    fast_rc_clk <= (cyc % 8) < 4;
    slow_crystal_clk <= (cyc % 10) < 5;
    enhanced_rc_clk <= (cyc % 12) < 6;
    if (crystal_ready_interrupt === 1'b1) begin
      irq_count <= irq_count + 1;
    end
  end

  // ===========================================
  // Helpers
  function automatic logic [6:0] therm(input logic [2:0] v);
    therm = 7'((8'h01 << v) - 8'h01);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(0, a, 32'h0);
      n++;
    end while (rd[b] !== v && n < 300);
    if (n >= 300) begin
      errors++;
      summarize();
    end
  endtask

  task automatic chk_banks(input logic [7:0] t);
    chk("bank a bin", 32'(bank_a_bin_sel), 32'(t[4:0]));
    chk("bank a therm", 32'(bank_a_therm_sel), 32'(therm(t[7:5])));
    chk("bank b bin", 32'(bank_b_bin_sel), 32'(t[4:0]));
    chk("bank b therm", 32'(bank_b_therm_sel), 32'(therm(t[7:5])));
  endtask

  // Request pulse: 0 power-up, 1 wake-up, 2 sleep
  task automatic pulse(input int k);
    @(posedge pclk);
    if (k == 0) power_up_req <= 1;
    else if (k == 1) wake_up_req <= 1;
    else sleep_req <= 1;
    @(posedge pclk);
    power_up_req <= 0;
    wake_up_req <= 0;
    sleep_req <= 0;
  endtask

  // ===========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 6; i++) begin
      apb(0, radr[i], 32'h0);
      chk("reset value", rd, rval[i]);
    end
    apb(0, `OTC_ADDR_STAT, 32'h0);
    chk("status at reset", rd, 32'h0);
    apb(0, 8'h2C, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    @(posedge pclk);
    ce <= 0;
    @(posedge pclk);
    chk("pready with ce low", 32'(pready), 32'h0);
    ce <= 1;
    // Power-up in counter mode
    apb(1, `OTC_ADDR_CNTLIM, 32'h5);
    apb(1, `OTC_ADDR_RDYLIM, 32'h2);
    apb(1, `OTC_ADDR_TCTRL, 32'h0300);
    tv = 8'($random(seed));
    apb(1, `OTC_ADDR_TRIM, 32'(tv));
    chk_banks(8'h00);
    pulse(0);
    @(posedge pclk);
    chk("xtal enable", 32'(xtal_enable), 32'h1);
    chk("slow rc fast", 32'(slow_rc_fast_sel), 32'h1);
    poll(`OTC_ADDR_STAT, 1, 1'b1);
    chk("status after settle", rd, 32'hE);
    chk_banks(tv);
    chk("ready pulses", 32'(irq_count), 32'h1);
    repeat (3) @(posedge pclk);
    chk("slow rc back", 32'(slow_rc_fast_sel), 32'h0);
    // Corner codes first, then random ones; banks follow the register
    for (int i = 0; i < 10; i++) begin
      tv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      apb(1, `OTC_ADDR_TRIM, 32'(tv));
      repeat (2) @(posedge pclk);
      chk_banks(tv);
    end
    pulse(2);
    repeat (2) @(posedge pclk);
    chk("xtal off", 32'(xtal_enable), 32'h0);
    apb(0, `OTC_ADDR_STAT, 32'h0);
    chk("status after sleep", rd, 32'h0);
    // Wake-up in current mode, five low-power ticks before the drop
    apb(1, `OTC_ADDR_TCTRL, 32'h0301);
    apb(0, `OTC_ADDR_TCTRL, 32'h0);
    chk("mode field", rd, 32'h0301);
    pulse(1);
    repeat (3) @(posedge pclk);
    repeat (5) begin
      lp_clk <= 1;
      repeat (3) @(posedge pclk);
      lp_clk <= 0;
      repeat (3) @(posedge pclk);
    end
    current_drop <= 1;
    repeat (3) @(posedge pclk);
    current_drop <= 0;
    apb(0, `OTC_ADDR_SNAP, 32'h0);
    chk("snapshot", rd, 32'h5);
    apb(0, `OTC_ADDR_STAT, 32'h0);
    chk("wake status", rd & 32'h5, 32'h5);
    chk("ready pulses", 32'(irq_count), 32'h2);
    apb(1, `OTC_ADDR_GPD, 32'h20);
    // The register updates on the access edge, so look one edge later
    @(posedge pclk);
    chk("gp data", 32'(gp_data), 32'h20);
    apb(1, `OTC_ADDR_GPD, 32'h40);
    apb(0, `OTC_ADDR_GPD, 32'h0);
    chk("gp data read", rd, 32'h40);
    // recalibrate after wake
    // Calibration of every source over four periods
    apb(1, `OTC_ADDR_REFN, 32'h4);
    for (int s = 0; s < 4; s++) begin
      apb(1, `OTC_ADDR_REFSEL, 32'h8000 | 32'(s));
      apb(0, `OTC_ADDR_REFSEL, 32'h0);
      chk("start bit", rd, 32'h8000 | 32'(s));
      apb(1, `OTC_ADDR_REFN, 32'h9);
      apb(0, `OTC_ADDR_REFN, 32'h0);
      chk("window kept", rd, 32'h4);
      poll(`OTC_ADDR_REFSEL, 15, 1'b0);
      apb(0, `OTC_ADDR_RESH, 32'h0);
      m[31:16] = rd[15:0];
      apb(0, `OTC_ADDR_RESL, 32'h0);
      m[15:0] = rd[15:0];
      chk("count", 32'(m + 1 >= 4 * (3 + s) && m <= 4 * (3 + s) + 1), 32'h1);
    end
    summarize();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    summarize();
  end
endmodule

// *** verilog/otc_osc_ctrl.sv ***
// Oscillator trim, start-up settling and reference-counter calibration
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "otc_params.svh"

// Operation
// - Code 0x00 gives least load capacitance; 0xFF gives the most.
// - Capacitance steps evenly over 256 codes of the 8-bit trim.
// - One trim register drives both capacitor banks identically.
// - Trim bits 4:0 drive binary-weighted capacitor selects directly.
// - Trim bits 7:5 decode to a seven-line thermometer code.
// - Ready interrupt fires when start-up counter equals programmed ready limit.
// - Start-up counter ticks on fast RC at power-up, low-power clock at wake.
// - Hardware enables the fast crystal on power-up and wake-up.
// - Counter mode applies stored trim when counter reaches limit minus one.
// - Trim-select field picks counter or current mode; counter after reset.
// - Current mode applies trim when oscillator current drop is seen.
// - Current mode snapshots the running counter when trim is applied.
// - Settle-ready flag sets once settle counter reaches the threshold.
// - During power-up the slow RC runs at 512 kHz instead of 32 kHz.
// - Reference counter counts a 16 MHz crystal-derived clock.
// - Source code 0 slow RC, 1 fast RC, 2 slow crystal, 3 enhanced RC.
// - Writing start bit begins measurement; hardware clears it when done.
// - Window lasts N programmed periods of the measured clock.
// - Reference count M is returned as 32 bits in high and low registers.
module otc_osc_ctrl
  import otc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_up_req,
  input wire logic wake_up_req,
  input wire logic sleep_req,
  input wire logic fast_rc_clk,
  input wire logic lp_clk,
  input wire logic current_drop,
  input wire logic slow_rc_clk,
  input wire logic slow_crystal_clk,
  input wire logic enhanced_rc_clk,
  input wire logic ref_clk_16m,
  output logic xtal_enable,
  output logic crystal_ready_interrupt,
  output logic slow_rc_fast_sel,
  output logic [4:0] bank_a_bin_sel,
  output logic [6:0] bank_a_therm_sel,
  output logic [4:0] bank_b_bin_sel,
  output logic [6:0] bank_b_therm_sel,
  output logic [7:0] gp_data
);

  // ===========================================
  // Registers and state
  logic [7:0] crystal_load_trim;
  otc_trim_mode_t trim_apply_select;
  logic [7:0] settle_threshold;
  logic [15:0] ready_count_limit;
  logic [15:0] startup_count_limit;
  logic [15:0] startup_count_snapshot;
  logic [1:0] ref_source;
  logic cal_start;
  logic [15:0] reference_window_count;
  logic [31:0] cal_result;
  otc_start_state_t st_state;
  logic wake_phase;
  logic tick_prev;
  logic [15:0] startup_cnt;
  logic [7:0] settle_counter;
  logic settle_ready_flag;
  logic trim_applied_flag;
  logic irq_done;
  logic [7:0] applied_trim;
  logic [7:0] next_applied;
  otc_cal_state_t cal_state;
  logic meas_prev;
  logic ref_prev;
  logic [31:0] m_cnt;
  logic [15:0] win_cnt;

  // ===========================================
  // APB slave
  logic wr_en;
  logic setup_rd;
  logic addr_hit;
  logic [31:0] rd_mux;

  assign wr_en = ce && psel && penable && pwrite;
  assign setup_rd = ce && psel && !penable && !pwrite;
  // A frozen block must not complete transfers
  assign pready = ce;
  assign pslverr = psel && penable && !addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OTC_ADDR_TRIM: rd_mux[7:0] = crystal_load_trim;
      `OTC_ADDR_TCTRL: begin
        rd_mux[`OTC_TCTRL_MODE] = trim_apply_select;
        rd_mux[`OTC_TCTRL_THR_LSB +: 8] = settle_threshold;
      end
      `OTC_ADDR_RDYLIM: rd_mux[15:0] = ready_count_limit;
      `OTC_ADDR_CNTLIM: rd_mux[15:0] = startup_count_limit;
      `OTC_ADDR_SNAP: rd_mux[15:0] = startup_count_snapshot;
      `OTC_ADDR_STAT: rd_mux[3:0] = {xtal_enable, trim_applied_flag, settle_ready_flag,
                                     wake_phase};
      `OTC_ADDR_REFSEL: begin
        rd_mux[1:0] = ref_source;
        rd_mux[`OTC_REFSEL_START] = cal_start;
      end
      `OTC_ADDR_REFN: rd_mux[15:0] = reference_window_count;
      `OTC_ADDR_RESH: rd_mux[15:0] = cal_result[31:16];
      `OTC_ADDR_RESL: rd_mux[15:0] = cal_result[15:0];
      `OTC_ADDR_GPD: rd_mux[7:0] = gp_data;
      default: addr_hit = 1'b0;
    endcase
  end

  // Read data is latched in the setup phase so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_load_trim <= `OTC_RST_TRIM;
      trim_apply_select <= OTC_MODE_COUNTER;
      settle_threshold <= `OTC_RST_THR;
      ready_count_limit <= `OTC_RST_RDYLIM;
      startup_count_limit <= `OTC_RST_CNTLIM;
      ref_source <= OTC_SRC_SLOW_RC;
      reference_window_count <= `OTC_RST_REFN;
      gp_data <= `OTC_RST_GPD;
    end else if (wr_en) begin
      case (paddr)
        `OTC_ADDR_TRIM: crystal_load_trim <= pwdata[7:0];
        `OTC_ADDR_TCTRL: begin
          trim_apply_select <= otc_trim_mode_t'(pwdata[`OTC_TCTRL_MODE]);
          settle_threshold <= pwdata[`OTC_TCTRL_THR_LSB +: 8];
        end
        `OTC_ADDR_RDYLIM: ready_count_limit <= pwdata[15:0];
        `OTC_ADDR_CNTLIM: startup_count_limit <= pwdata[15:0];
        // Source cannot change under a running measurement
        `OTC_ADDR_REFSEL: if (!cal_start) ref_source <= pwdata[1:0];
        `OTC_ADDR_REFN: if (!cal_start) reference_window_count <= pwdata[15:0];
        `OTC_ADDR_GPD: gp_data <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ===========================================
  // Start-up sequencer
  logic sel_lvl;
  logic tick;
  logic apply_now;

  assign sel_lvl = wake_phase ? lp_clk : fast_rc_clk;
  assign tick = sel_lvl && !tick_prev;

  assign apply_now = (st_state == OTC_ST_START) &&
    ((trim_apply_select == OTC_MODE_CURRENT) ? current_drop :
     (startup_cnt == startup_count_limit - 16'h0001));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_state <= OTC_ST_OFF;
      wake_phase <= 1'b0;
      xtal_enable <= 1'b0;
    end else if (ce) begin
      if (sleep_req) begin
        st_state <= OTC_ST_OFF;
        xtal_enable <= 1'b0;
      end else begin
        case (st_state)
          OTC_ST_OFF: begin
            if (power_up_req || wake_up_req) begin
              st_state <= OTC_ST_START;
              wake_phase <= !power_up_req;
              xtal_enable <= 1'b1;
            end
          end
          OTC_ST_START: if (apply_now) st_state <= OTC_ST_SETTLE;
          OTC_ST_SETTLE: ;
          default: st_state <= OTC_ST_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_prev <= 1'b0;
      startup_cnt <= 16'h0000;
      settle_counter <= 8'h00;
    end else if (ce) begin
      tick_prev <= sel_lvl;
      if (st_state == OTC_ST_OFF) begin
        startup_cnt <= 16'h0000;
        settle_counter <= 8'h00;
      end else if (tick) begin
        if (startup_cnt != 16'hFFFF) startup_cnt <= startup_cnt + 16'h0001;
        if (st_state == OTC_ST_SETTLE && settle_counter != 8'hFF)
          settle_counter <= settle_counter + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_ready_flag <= 1'b0;
    end else if (ce) begin
      settle_ready_flag <= (st_state == OTC_ST_SETTLE) &&
                           (settle_counter >= settle_threshold);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_ready_interrupt <= 1'b0;
      irq_done <= 1'b0;
    end else if (ce) begin
      crystal_ready_interrupt <= 1'b0;
      if (st_state == OTC_ST_OFF) begin
        irq_done <= 1'b0;
      end else if (!irq_done && startup_cnt == ready_count_limit) begin
        crystal_ready_interrupt <= 1'b1;
        irq_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_applied_flag <= 1'b0;
      startup_count_snapshot <= 16'h0000;
    end else if (ce) begin
      if (st_state == OTC_ST_OFF) trim_applied_flag <= 1'b0;
      else if (apply_now) trim_applied_flag <= 1'b1;
      if (apply_now && trim_apply_select == OTC_MODE_CURRENT)
        startup_count_snapshot <= startup_cnt;
    end
  end

  // fast sequencer clock only while powering up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_rc_fast_sel <= 1'b0;
    end else if (ce) begin
      if (sleep_req || settle_ready_flag) slow_rc_fast_sel <= 1'b0;
      else if (power_up_req && st_state == OTC_ST_OFF) slow_rc_fast_sel <= 1'b1;
    end
  end

  // ===========================================
  // Capacitor bank drive
  function automatic logic [6:0] otc_therm(input logic [2:0] v);
    logic [6:0] t;
    t = 7'h00;
    for (int i = 0; i < 7; i++) begin
      t[i] = (3'(i) < v);
    end
    return t;
  endfunction

  // Later writes follow through once the start-up trim is in place
  always_comb begin
    next_applied = applied_trim;
    if (apply_now) next_applied = crystal_load_trim;
    else if (trim_applied_flag && wr_en && paddr == `OTC_ADDR_TRIM)
      next_applied = pwdata[7:0];
  end

  // 256 equal steps from the weights below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_trim <= 8'h00;
      bank_a_bin_sel <= 5'h00;
      bank_a_therm_sel <= 7'h00;
      bank_b_bin_sel <= 5'h00;
      bank_b_therm_sel <= 7'h00;
    end else if (ce) begin
      applied_trim <= next_applied;
      bank_a_bin_sel <= next_applied[4:0];
      bank_b_bin_sel <= next_applied[4:0];
      bank_a_therm_sel <= otc_therm(next_applied[7:5]);
      bank_b_therm_sel <= otc_therm(next_applied[7:5]);
    end
  end

  // ===========================================
  // Reference counter calibration
  logic meas_lvl;
  logic meas_edge;
  logic ref_edge;
  logic cal_last;

  always_comb begin
    case (ref_source)
      OTC_SRC_SLOW_RC: meas_lvl = slow_rc_clk;
      OTC_SRC_FAST_RC: meas_lvl = fast_rc_clk;
      OTC_SRC_SLOW_XTAL: meas_lvl = slow_crystal_clk;
      default: meas_lvl = enhanced_rc_clk;
    endcase
  end

  assign meas_edge = meas_lvl && !meas_prev;
  assign ref_edge = ref_clk_16m && !ref_prev;
  // window end after N periods; N of zero means 65536
  assign cal_last = (cal_state == OTC_CAL_RUN) && meas_edge &&
                    (win_cnt == reference_window_count - 16'h0001);

  // start by write, cleared on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_start <= 1'b0;
      cal_state <= OTC_CAL_IDLE;
      meas_prev <= 1'b0;
      ref_prev <= 1'b0;
      m_cnt <= 32'h0000_0000;
      win_cnt <= 16'h0000;
      cal_result <= 32'h0000_0000;
    end else if (ce) begin
      meas_prev <= meas_lvl;
      ref_prev <= ref_clk_16m;
      case (cal_state)
        OTC_CAL_IDLE: begin
          if (wr_en && paddr == `OTC_ADDR_REFSEL && pwdata[`OTC_REFSEL_START]) begin
            cal_start <= 1'b1;
            cal_state <= OTC_CAL_SYNC;
          end
        end
        // Window opens on a measured edge so N whole periods are seen
        OTC_CAL_SYNC: begin
          if (meas_edge) begin
            cal_state <= OTC_CAL_RUN;
            m_cnt <= 32'h0000_0000;
            win_cnt <= 16'h0000;
          end
        end
        OTC_CAL_RUN: begin
          if (cal_last) begin
            cal_result <= m_cnt + {31'h0000_0000, ref_edge};
            cal_start <= 1'b0;
            cal_state <= OTC_CAL_IDLE;
          end else begin
            if (ref_edge) m_cnt <= m_cnt + 32'h0000_0001;
            if (meas_edge) win_cnt <= win_cnt + 16'h0001;
          end
        end
        default: cal_state <= OTC_CAL_IDLE;
      endcase
    end
  end

  // ===========================================
  // Checks
  sequence cal_window_end;
    ce && cal_last;
  endsequence

  sequence cal_closed;
    !cal_start && cal_state == OTC_CAL_IDLE;
  endsequence

  bank_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    bank_a_bin_sel == bank_b_bin_sel && bank_a_therm_sel == bank_b_therm_sel)
    else $error("capacitor banks differ");

  therm_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> $countones(bank_a_therm_sel) == 32'(applied_trim[7:5]) &&
           ((bank_a_therm_sel & (bank_a_therm_sel + 7'h01)) == 7'h00))
    else $error("thermometer code wrong");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_state != OTC_ST_OFF && !irq_done && startup_cnt == ready_count_limit
    |=> crystal_ready_interrupt ##1 (!crystal_ready_interrupt || !ce))
    else $error("ready pulse missing or long");

  counter_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !sleep_req && st_state == OTC_ST_START && trim_apply_select == OTC_MODE_COUNTER
    && startup_cnt == startup_count_limit - 16'h0001
    |=> trim_applied_flag && applied_trim == $past(crystal_load_trim))
    else $error("counter mode trim not applied");

  current_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_state == OTC_ST_START && trim_apply_select == OTC_MODE_CURRENT
    && current_drop |=> startup_count_snapshot == $past(startup_cnt)
    && applied_trim == $past(crystal_load_trim))
    else $error("current mode apply or snapshot wrong");

  settle_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_state == OTC_ST_SETTLE && settle_counter >= settle_threshold
    |=> settle_ready_flag)
    else $error("settle flag not set");

  cal_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    cal_window_end |=> cal_closed ##0 cal_result == $past(m_cnt) + 32'($past(ref_edge)))
    else $error("calibration end wrong");

  disable_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sleep_req |=> !xtal_enable ##1 (!$past(ce) || (startup_cnt == 16'h0000
    && !settle_ready_flag)))
    else $error("disable did not clear");

endmodule

// *** verilog/otc_params.svh ***
// Register map, field positions and reset values for the oscillator control block
`ifndef OTC_PARAMS_SVH
`define OTC_PARAMS_SVH

// ===========================================
// Register offsets (byte addresses)
`define OTC_ADDR_TRIM 8'h00
`define OTC_ADDR_TCTRL 8'h04
`define OTC_ADDR_RDYLIM 8'h08
`define OTC_ADDR_CNTLIM 8'h0C
`define OTC_ADDR_SNAP 8'h10
`define OTC_ADDR_STAT 8'h14
`define OTC_ADDR_REFSEL 8'h18
`define OTC_ADDR_REFN 8'h1C
`define OTC_ADDR_RESH 8'h20
`define OTC_ADDR_RESL 8'h24
`define OTC_ADDR_GPD 8'h28

// ===========================================
// Field positions
`define OTC_TCTRL_MODE 0
`define OTC_TCTRL_THR_LSB 8
`define OTC_REFSEL_START 15

// ===========================================
// Reset values
`define OTC_RST_TRIM 8'h80
`define OTC_RST_THR 8'h08
`define OTC_RST_RDYLIM 16'h0200
`define OTC_RST_CNTLIM 16'h0100
`define OTC_RST_REFN 16'h0010
`define OTC_RST_GPD 8'h00

`endif

// *** verilog/otc_pkg.sv ***
// Types shared by the oscillator control block
package otc_pkg;

  typedef enum logic [1:0] {
    OTC_ST_OFF = 2'b00,
    OTC_ST_START = 2'b01,
    OTC_ST_SETTLE = 2'b10
  } otc_start_state_t;

  typedef enum logic [1:0] {
    OTC_CAL_IDLE = 2'b00,
    OTC_CAL_SYNC = 2'b01,
    OTC_CAL_RUN = 2'b10
  } otc_cal_state_t;

  typedef enum logic [1:0] {
    OTC_SRC_SLOW_RC = 2'b00,
    OTC_SRC_FAST_RC = 2'b01,
    OTC_SRC_SLOW_XTAL = 2'b10,
    OTC_SRC_ENH_RC = 2'b11
  } otc_ref_src_t;

  typedef enum logic {
    OTC_MODE_COUNTER = 1'b0,
    OTC_MODE_CURRENT = 1'b1
  } otc_trim_mode_t;

endpackage
